// *** pipe_phy_model.sv ***
// PIPE PHY lane model that answers the link-layer side, with an Avalon-MM control port.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
module pipe_phy_model #(
  parameter int LANES       = pipe_phy_pkg::LANE_LIMIT,
  parameter int DONE_DELAY  = pipe_phy_pkg::DONE_DELAY_CYC,
  parameter int LOCK_CYCLES = pipe_phy_pkg::LOCK_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic [LANES*8-1:0] tx_lane_byte,
  input  wire logic [LANES-1:0]   tx_symbol_is_control,
  input  wire logic [LANES-1:0]   receiver_detect_req,
  input  wire logic [LANES-1:0]   tx_elec_idle_req,
  input  wire logic [LANES-1:0]   tx_compliance_negative,
  input  wire logic [LANES-1:0]   rx_invert_decode,
  input  wire logic [LANES*2-1:0] phy_power_state_req,
  input  wire logic [LANES-1:0]   tx_deemphasis_select,
  input  wire logic [LANES*3-1:0] idle_inference_select,
  input  wire logic [LANES-1:0]   tx_swing_select,
  input  wire logic [LANES*3-1:0] tx_margin_select,
  input  wire logic [4:0]         training_state_code,
  input  wire logic [1:0]         lane_rate,
  output logic [LANES*8-1:0]      rx_lane_byte,
  output logic [LANES*2-1:0]      rx_symbol_is_control,
  output logic [LANES-1:0]        rx_symbol_locked_valid,
  output logic [LANES-1:0]        phy_request_done,
  output logic [LANES-1:0]        rx_line_idle,
  output logic [LANES*3-1:0]      rx_status_code
);

  // Bounds for the status handshake: one request in flight plus one pending.
  localparam int DONE_BOUND = 12;

  if (LANES < 1 || LANES > pipe_phy_pkg::LANE_LIMIT)
  begin : g_bad_lanes
    $error("LANES must be 1 to 8");
  end
  if (DONE_DELAY < 1 || DONE_DELAY > 5)
  begin : g_bad_delay
    $error("DONE_DELAY must be 1 to 5");
  end

  function automatic logic [7:0] count_ones(input logic [LANES-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < LANES; i++)
      n = n + {7'h00, v[i]};
    return n;
  endfunction

  logic [1:0]       ctrl_q;
  logic             ack_q;
  logic [31:0]      readdata_q;
  logic [15:0]      dones_q;
  logic [1:0]       rate_q;
  logic             rate_change;
  logic [LANES-1:0] inferred;
  logic             loopback_en;
  logic             rx_present;

  assign loopback_en = ctrl_q[pipe_phy_pkg::CTRL_LOOPBACK_BIT];
  assign rx_present  = ctrl_q[pipe_phy_pkg::CTRL_PRESENT_BIT];
  assign rate_change = (lane_rate != rate_q);

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rate_q <= pipe_phy_pkg::RATE_GEN1;
    else
      rate_q <= lane_rate;
  end

  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    pipe_phy_pkg::seq_state_t state_q;
    logic [2:0]  cnt_q;
    logic [1:0]  pwr_q;
    logic        det_q;
    logic        pend_q;
    logic        kind_q;
    logic        found_q;
    logic        req;
    logic        det_rise;
    logic        active;
    logic [1:0]  pwr_now;

    assign pwr_now  = phy_power_state_req[2*i +: 2];
    assign det_rise = receiver_detect_req[i] && !det_q;
    assign req      = (pwr_now != pwr_q) || rate_change || det_rise;

    // Received bytes always pass; they are flagged valid only with loopback on, in P0, while the transmitter is not held idle.
    assign active = loopback_en && !tx_elec_idle_req[i] &&
                    pwr_q == pipe_phy_pkg::PWR_P0;

    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
      begin
        pwr_q <= pipe_phy_pkg::PWR_RESET;
        det_q <= 1'b0;
      end
      else
      begin
        pwr_q <= pwr_now;
        det_q <= receiver_detect_req[i];
      end
    end

    // A request arriving while one is in flight is kept; the set beats the clear.
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        pend_q <= 1'b0;
      else if (req && state_q != pipe_phy_pkg::SEQ_IDLE)
        pend_q <= 1'b1;
      else if (state_q == pipe_phy_pkg::SEQ_IDLE)
        pend_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
      begin
        state_q <= pipe_phy_pkg::SEQ_IDLE;
        cnt_q   <= 3'h0;
        kind_q  <= 1'b0;
        found_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          pipe_phy_pkg::SEQ_IDLE:
          begin
            if (req || pend_q)
            begin
              state_q <= pipe_phy_pkg::SEQ_WAIT;
              cnt_q   <= 3'(DONE_DELAY - 1);
              kind_q  <= det_rise || kind_q;
              found_q <= rx_present;
            end
          end
          pipe_phy_pkg::SEQ_WAIT:
          begin
            if (det_rise)
              kind_q <= 1'b1;
            if (cnt_q == 3'h0)
              state_q <= pipe_phy_pkg::SEQ_DONE;
            else
              cnt_q <= cnt_q - 3'h1;
          end
          pipe_phy_pkg::SEQ_DONE:
          begin
            state_q <= pipe_phy_pkg::SEQ_IDLE;
            kind_q  <= det_rise;
          end
          default:
            state_q <= pipe_phy_pkg::SEQ_IDLE;
        endcase
      end
    end

    assign phy_request_done[i] = (state_q == pipe_phy_pkg::SEQ_DONE);
    assign rx_status_code[3*i +: 3] =
      (state_q == pipe_phy_pkg::SEQ_DONE && kind_q && found_q) ?
      pipe_phy_pkg::RXST_DETECTED : pipe_phy_pkg::RXST_OK;

    // Only the byte output may be left open; the valid, control and idle outputs also feed the idle inference timer.
    pipe_phy_rx #(
      .LOCK_CYCLES (LOCK_CYCLES)
    ) u_rx (
      .sys_clk      (sys_clk),
      .resetn       (resetn),
      .active       (active),
      .invert       (rx_invert_decode[i]),
      .tx_byte      (tx_lane_byte[8*i +: 8]),
      .tx_control   (tx_symbol_is_control[i]),
      .rx_byte_q    (rx_lane_byte[8*i +: 8]),
      .rx_control_q (rx_symbol_is_control[2*i +: 2]),
      .rx_valid_q   (rx_symbol_locked_valid[i]),
      .rx_idle_q    (rx_line_idle[i])
    );

    pipe_phy_infer u_infer (
      .sys_clk         (sys_clk),
      .resetn          (resetn),
      .infer_select    (idle_inference_select[3*i +: 3]),
      .lane_rate       (lane_rate),
      .set_seen        (rx_symbol_locked_valid[i] && rx_symbol_is_control[2*i]),
      .idle_exit       (!rx_line_idle[i]),
      .idle_inferred_q (inferred[i])
    );

    a_done_one_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
      phy_request_done[i] |=> !phy_request_done[i]) else $error("done longer than a cycle");

    a_power_done_due: assert property (@(posedge sys_clk) disable iff (!resetn)
      (pwr_now != pwr_q) |-> ##[1:DONE_BOUND] phy_request_done[i])
      else $error("power change not acknowledged");

    a_detect_status: assert property (@(posedge sys_clk) disable iff (!resetn)
      rx_status_code[3*i +: 3] != pipe_phy_pkg::RXST_OK |-> phy_request_done[i])
      else $error("detect status outside done pulse");

    a_txidle_rxidle: assert property (@(posedge sys_clk) disable iff (!resetn)
      tx_elec_idle_req[i] |=> rx_line_idle[i] && !rx_symbol_locked_valid[i])
      else $error("symbols while tx held idle");
  end

  // Avalon-MM slave: every access takes one wait cycle, then completes.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign avs_readdata    = readdata_q;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read || avs_write) && !ack_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      ctrl_q <= pipe_phy_pkg::CTRL_RESET;
    else if (avs_write && ack_q && avs_address == pipe_phy_pkg::REG_CTRL && avs_byteenable[0])
      ctrl_q <= avs_writedata[1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      dones_q <= 16'h0000;
    else
      dones_q <= dones_q + {8'h00, count_ones(phy_request_done)};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      readdata_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      readdata_q <= 32'h0000_0000;
      case (avs_address)
        pipe_phy_pkg::REG_CTRL:
          readdata_q <= {30'h0000_0000, ctrl_q};
        pipe_phy_pkg::REG_STATE:
        begin
          readdata_q[4:0] <= training_state_code;
          readdata_q[pipe_phy_pkg::STATE_RATE_POS +: 2] <= lane_rate;
        end
        pipe_phy_pkg::REG_POWER:
          readdata_q[15:0] <= 16'(phy_power_state_req);
        pipe_phy_pkg::REG_FLAGS:
        begin
          readdata_q[7:0] <= 8'(tx_compliance_negative);
          readdata_q[pipe_phy_pkg::FLAGS_POL_POS +: 8] <= 8'(rx_invert_decode);
          readdata_q[pipe_phy_pkg::FLAGS_SWING_POS +: 8] <= 8'(tx_swing_select);
          readdata_q[pipe_phy_pkg::FLAGS_DEEMPH_POS +: 8] <= 8'(tx_deemphasis_select);
        end
        pipe_phy_pkg::REG_MARGIN:
          readdata_q[23:0] <= 24'(tx_margin_select);
        pipe_phy_pkg::REG_INFER:
          readdata_q[23:0] <= 24'(idle_inference_select);
        pipe_phy_pkg::REG_IDLE:
        begin
          readdata_q[7:0] <= 8'(inferred);
          readdata_q[pipe_phy_pkg::IDLE_LINE_POS +: 8] <= 8'(rx_line_idle);
        end
        pipe_phy_pkg::REG_DONES:
          readdata_q[15:0] <= dones_q;
        default:
          readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus access not exactly one wait cycle");

endmodule

// *** pipe_phy_pkg.sv ***
// Shared constants and types for the PIPE PHY lane model.
package pipe_phy_pkg;

  localparam int LANE_LIMIT = 8;

  // Control and status registers reached over the Avalon-MM slave port.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATE  = 8'h04;
  localparam logic [7:0] REG_POWER  = 8'h08;
  localparam logic [7:0] REG_FLAGS  = 8'h0C;
  localparam logic [7:0] REG_MARGIN = 8'h10;
  localparam logic [7:0] REG_INFER  = 8'h14;
  localparam logic [7:0] REG_IDLE   = 8'h18;
  localparam logic [7:0] REG_DONES  = 8'h1C;

  localparam int          CTRL_LOOPBACK_BIT = 0;
  localparam int          CTRL_PRESENT_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET        = 2'h0;
  localparam int          STATE_RATE_POS    = 8;
  localparam int          FLAGS_POL_POS     = 8;
  localparam int          FLAGS_SWING_POS   = 16;
  localparam int          FLAGS_DEEMPH_POS  = 24;
  localparam int          IDLE_LINE_POS     = 8;

  typedef enum logic [1:0] {
    PWR_P0  = 2'h0,
    PWR_P0S = 2'h1,
    PWR_P1  = 2'h2,
    PWR_P2  = 2'h3
  } power_state_t;

  localparam power_state_t PWR_RESET = PWR_P1;

  localparam logic [1:0] RATE_GEN1 = 2'h0;
  localparam logic [1:0] RATE_GEN2 = 2'h1;

  localparam logic [4:0] TRN_DETECT_QUIET  = 5'h00;
  localparam logic [4:0] TRN_DETECT_ACTIVE = 5'h01;
  localparam logic [4:0] TRN_POLL_ACTIVE   = 5'h02;
  localparam logic [4:0] TRN_L0            = 5'h0F;
  localparam logic [4:0] TRN_DISABLE       = 5'h10;
  localparam logic [4:0] TRN_LOOP_ENTRY    = 5'h11;
  localparam logic [4:0] TRN_LOOP_EXIT     = 5'h12;
  localparam logic [4:0] TRN_SPEED_RECOV   = 5'h1A;

  localparam logic [2:0] RXST_OK       = 3'h0;
  localparam logic [2:0] RXST_DETECTED = 3'h3;

  localparam logic [2:0] INFER_COM_SKP   = 3'h4;
  localparam logic [2:0] INFER_TS        = 3'h5;
  localparam logic [2:0] INFER_EXIT_UI   = 3'h6;
  localparam logic [2:0] INFER_EXIT_WIN  = 3'h7;

  // Timing, with every figure in its own unit and the cycle counts derived.
  localparam int CLK_PERIOD_PS = 100000;
  localparam int WINDOW_US     = 128;
  localparam int TS_SPAN_UI    = 1280;
  localparam int EXIT_UI_GEN1  = 2000;
  localparam int EXIT_UI_GEN2  = 16000;
  localparam int UI_GEN1_PS    = 400;
  localparam int UI_GEN2_PS    = 200;
  localparam int WINDOW_CYC    = (WINDOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TS_GEN1_CYC   = (TS_SPAN_UI * UI_GEN1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TS_GEN2_CYC   = (TS_SPAN_UI * UI_GEN2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXIT_GEN1_CYC = (EXIT_UI_GEN1 * UI_GEN1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXIT_GEN2_CYC = (EXIT_UI_GEN2 * UI_GEN2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int DONE_DELAY_CYC = 4;
  localparam int LOCK_CYC       = 4;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_DONE = 2'b11
  } seq_state_t;

endpackage

// *** pipe_phy_infer.sv ***
// Electrical-idle inference timer for one lane.
`timescale 1ns/1ns
module pipe_phy_infer (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] infer_select,
  input  wire logic [1:0] lane_rate,
  input  wire logic       set_seen,
  input  wire logic       idle_exit,
  output logic            idle_inferred_q
);

  logic [15:0] cnt_q;
  logic [2:0]  sel_q;
  logic [15:0] limit;
  logic        activity;
  logic        gen2;

  assign gen2 = (lane_rate == pipe_phy_pkg::RATE_GEN2);

  always_comb
  begin
    limit    = 16'h0000;
    activity = 1'b0;
    case (infer_select)
      pipe_phy_pkg::INFER_COM_SKP:
      begin
        limit    = 16'(pipe_phy_pkg::WINDOW_CYC);
        activity = set_seen;
      end
      pipe_phy_pkg::INFER_TS:
      begin
        limit    = gen2 ? 16'(pipe_phy_pkg::TS_GEN2_CYC)
                        : 16'(pipe_phy_pkg::TS_GEN1_CYC);
        activity = set_seen;
      end
      pipe_phy_pkg::INFER_EXIT_UI:
      begin
        limit    = gen2 ? 16'(pipe_phy_pkg::EXIT_GEN2_CYC)
                        : 16'(pipe_phy_pkg::EXIT_GEN1_CYC);
        activity = idle_exit;
      end
      pipe_phy_pkg::INFER_EXIT_WIN:
      begin
        // Defined for every rate except the second-generation one; at that rate it never fires.
        limit    = gen2 ? 16'h0000 : 16'(pipe_phy_pkg::WINDOW_CYC);
        activity = idle_exit;
      end
      default:
      begin
        limit    = 16'h0000;
        activity = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || activity || infer_select != sel_q || limit == 16'h0000)
      cnt_q <= 16'h0000;
    else if (cnt_q != limit)
      cnt_q <= cnt_q + 16'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      sel_q           <= 3'h0;
      idle_inferred_q <= 1'b0;
    end
    else
    begin
      sel_q           <= infer_select;
      idle_inferred_q <= (limit != 16'h0000) && (cnt_q == limit) && !activity;
    end
  end

  a_infer_off_none: assert property (@(posedge sys_clk) disable iff (!resetn)
    !infer_select[2] |=> !idle_inferred_q) else $error("inference with select 0xx");

  a_infer_gen1_only: assert property (@(posedge sys_clk) disable iff (!resetn)
    (infer_select == 3'h7 && gen2) |=> !idle_inferred_q)
    else $error("exit window inferred at gen2");

endmodule

// *** pipe_phy_rx.sv ***
// Receive path of one lane: looped-back symbols, lock and idle indication.
`timescale 1ns/1ns
module pipe_phy_rx #(
  parameter int LOCK_CYCLES = pipe_phy_pkg::LOCK_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       active,
  input  wire logic       invert,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_control,
  output logic [7:0]      rx_byte_q,
  output logic [1:0]      rx_control_q,
  output logic            rx_valid_q,
  output logic            rx_idle_q
);

  logic [7:0] lock_cnt_q;

  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 255)
  begin : g_bad_lock
    $error("LOCK_CYCLES out of range");
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !active)
      lock_cnt_q <= 8'h00;
    else if (lock_cnt_q != 8'(LOCK_CYCLES))
      lock_cnt_q <= lock_cnt_q + 8'h01;
  end

  // Inversion of the line polarity shows up after decode as a complemented byte.
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      rx_byte_q    <= 8'h00;
      rx_control_q <= 2'h0;
      rx_valid_q   <= 1'b0;
      rx_idle_q    <= 1'b1;
    end
    else
    begin
      rx_byte_q    <= invert ? ~tx_byte : tx_byte;
      rx_control_q <= {1'b0, tx_control};
      rx_valid_q   <= active && lock_cnt_q == 8'(LOCK_CYCLES);
      rx_idle_q    <= !active;
    end
  end

  a_rx_byte_path: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 rx_byte_q == ($past(invert) ? ~$past(tx_byte) : $past(tx_byte)))
    else $error("rx byte not the decoded tx byte");

  a_rx_ctrl_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 rx_control_q == {1'b0, $past(tx_control)}) else $error("control flag wrong");

  a_rx_valid_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_valid_q |-> !rx_idle_q ##0 $past(active)) else $error("valid while idle");

endmodule

// *** pipe_mac_partner.sv ***
// Link-layer side model that drives the per-lane controls toward the PHY lane model.
`timescale 1ns/1ns
module pipe_mac_partner (
  input  wire logic  sys_clk,
  output logic [63:0] tx_lane_byte,
  output logic [7:0]  tx_symbol_is_control,
  output logic [7:0]  receiver_detect_req,
  output logic [7:0]  tx_elec_idle_req,
  output logic [7:0]  tx_compliance_negative,
  output logic [7:0]  rx_invert_decode,
  output logic [15:0] phy_power_state_req,
  output logic [7:0]  tx_deemphasis_select,
  output logic [23:0] idle_inference_select,
  output logic [7:0]  tx_swing_select,
  output logic [23:0] tx_margin_select,
  output logic [4:0]  training_state_code,
  output logic [1:0]  lane_rate
);
  // Power starts at P1 and rate at Gen1 so that reset alone raises no request.
  initial
  begin
    {tx_lane_byte, tx_symbol_is_control, receiver_detect_req} = '0;
    {tx_compliance_negative, rx_invert_decode, tx_deemphasis_select} = '0;
    {idle_inference_select, tx_swing_select, tx_margin_select} = '0;
    tx_elec_idle_req    = 8'hFF;
    phy_power_state_req = 16'hAAAA;
    training_state_code = 5'h00;
    lane_rate           = 2'h0;
  end

  task automatic set_ctl(input logic [7:0] idle, input logic [7:0] det, input logic [15:0] pwr);
    @(posedge sys_clk);
    tx_elec_idle_req    <= idle;
    receiver_detect_req <= det;
    phy_power_state_req <= pwr;
  endtask

  task automatic set_flags(input logic [31:0] f, input logic [23:0] m, input logic [23:0] s);
    @(posedge sys_clk);
    {tx_deemphasis_select, tx_swing_select, rx_invert_decode, tx_compliance_negative} <= f;
    tx_margin_select      <= m;
    idle_inference_select <= s;
  endtask

  task automatic set_trn(input logic [4:0] c, input logic [1:0] r);
    @(posedge sys_clk);
    training_state_code <= c;
    lane_rate           <= r;
  endtask

  task automatic send(input logic [63:0] b, input logic [7:0] k);
    @(posedge sys_clk);
    tx_lane_byte         <= b;
    tx_symbol_is_control <= k;
  endtask
endmodule

// *** pipe_phy_model_test.sv ***
// Self-checking bench for the PIPE PHY lane model.
`timescale 1ns/1ns
module pipe_phy_model_test;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [63:0] tx_b, rx_b;
  logic [7:0]  tx_k, det, eidle, cmp, pol, dem, swg, done, valid, rx_idle;
  logic [15:0] pwr, rx_k;
  logic [23:0] inf, mrg, st;
  logic [4:0]  trn;
  logic [1:0]  rate;
  logic [31:0] seed = 32'h00000B58;
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #50 sys_clk = ~sys_clk;

  pipe_mac_partner i_pipe_mac_partner (.sys_clk(sys_clk), .tx_lane_byte(tx_b),
    .tx_symbol_is_control(tx_k), .receiver_detect_req(det), .tx_elec_idle_req(eidle),
    .tx_compliance_negative(cmp), .rx_invert_decode(pol), .phy_power_state_req(pwr),
    .tx_deemphasis_select(dem), .idle_inference_select(inf), .tx_swing_select(swg),
    .tx_margin_select(mrg), .training_state_code(trn), .lane_rate(rate));

  pipe_phy_model i_pipe_phy_model (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_lane_byte(tx_b), .tx_symbol_is_control(tx_k),
    .receiver_detect_req(det), .tx_elec_idle_req(eidle), .tx_compliance_negative(cmp),
    .rx_invert_decode(pol), .phy_power_state_req(pwr), .tx_deemphasis_select(dem),
    .idle_inference_select(inf), .tx_swing_select(swg), .tx_margin_select(mrg),
    .training_state_code(trn), .lane_rate(rate), .rx_lane_byte(rx_b),
    .rx_symbol_is_control(rx_k), .rx_symbol_locked_valid(valid), .phy_request_done(done),
    .rx_line_idle(rx_idle), .rx_status_code(st));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // The request is held until waitrequest is seen low, whatever the answer delay.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(n, v, e);
  endtask

  task automatic wait_done(input logic [7:0] m, input logic [23:0] s);
    int n;
    n = 0;
    #1;
    while (done === 8'h00 && n < 14)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("done", done, m);
    check("status", st, s);
    @(posedge sys_clk);
    #1;
    check("done_pulse", done, 8'h00);
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    logic [31:0] f, m, s, v;
    logic [63:0] b, e;
    logic [7:0]  k, codes [8];
    logic [79:0] q[$];
    codes = '{8'h00, 8'h01, 8'h02, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h1A};
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    check("idle_rst", rx_idle, 8'hFF);
    check("valid_rst", valid, 8'h00);
    check("done_rst", done, 8'h00);
    rd_chk("ctrl_rst", pipe_phy_pkg::REG_CTRL, 32'h0);
    bus(1'b1, pipe_phy_pkg::REG_STATE, 32'hFFFFFFFF, v);
    rd_chk("state_ro", pipe_phy_pkg::REG_STATE, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    f = rnd();
    m = rnd();
    s = rnd();
    i_pipe_mac_partner.set_flags(f, m[23:0], s[23:0]);
    rd_chk("flags", pipe_phy_pkg::REG_FLAGS, f);
    rd_chk("margin", pipe_phy_pkg::REG_MARGIN, {8'h00, m[23:0]});
    rd_chk("infer", pipe_phy_pkg::REG_INFER, {8'h00, s[23:0]});
    $display("registers done");
    for (int i = 0; i < 8; i++)
    begin
      i_pipe_mac_partner.set_trn(codes[i][4:0], {1'b0, i[0]});
      rd_chk("state", pipe_phy_pkg::REG_STATE, {23'h0, i[0], 3'h0, codes[i][4:0]});
    end
    i_pipe_mac_partner.set_trn(pipe_phy_pkg::TRN_L0, pipe_phy_pkg::RATE_GEN1);
    repeat (20) @(posedge sys_clk);
    $display("state codes done");
    i_pipe_mac_partner.set_ctl(8'hFF, 8'h00, 16'h0000);
    wait_done(8'hFF, 24'h0);
    rd_chk("power", pipe_phy_pkg::REG_POWER, 32'h0);
    bus(1'b1, pipe_phy_pkg::REG_CTRL, 32'h2, v);
    i_pipe_mac_partner.set_ctl(8'hFF, 8'h81, 16'h0000);
    wait_done(8'h81, 24'h600003);
    i_pipe_mac_partner.set_ctl(8'hFF, 8'h00, 16'h0000);
    $display("requests done");
    bus(1'b1, pipe_phy_pkg::REG_CTRL, 32'h3, v);
    rd_chk("ctrl", pipe_phy_pkg::REG_CTRL, 32'h3);
    f = rnd();
    i_pipe_mac_partner.set_flags(f, 24'h0, 24'h0);
    i_pipe_mac_partner.set_ctl(8'h00, 8'h00, 16'h0000);
    for (int n = 0; n < 30 && valid !== 8'hFF; n++)
      @(posedge sys_clk);
    check("valid", valid, 8'hFF);
    check("idle", rx_idle, 8'h00);
    for (int i = 0; i < 17; i++)
    begin
      b = {rnd(), rnd()};
      k = rnd();
      i_pipe_mac_partner.send(b, k);
      for (int l = 0; l < 8; l++)
      begin
        e[l*8 +: 8] = b[l*8 +: 8] ^ {8{f[8+l]}};
        v[l*2 +: 2] = {1'b0, k[l]};
      end
      q.push_back({v[15:0], e});
      #1;
      if (q.size() == 2)
      begin
        e = q[0][63:0];
        check("rx_byte", rx_b, e);
        check("rx_ctl", rx_k, q.pop_front() >> 64);
      end
    end
    i_pipe_mac_partner.set_ctl(8'hFF, 8'h00, 16'h0000);
    repeat (3) @(posedge sys_clk);
    #1;
    check("idle_on", rx_idle, 8'hFF);
    check("valid_off", valid, 8'h00);
    $display("loopback done");
    for (int c = 3; c < 8; c++)
    begin
      i_pipe_mac_partner.set_flags(32'h0, 24'h0, {8{c[2:0]}});
      repeat (1300) @(posedge sys_clk);
      rd_chk("inferred", pipe_phy_pkg::REG_IDLE, {16'h0, 8'hFF, {8{c[2]}}});
    end
    $display("inference done");
    give_verdict();
  end
endmodule
